/* verilog/rrc_pkg.sv */
// Package: register map, config word layout and reset timer constants
`default_nettype none
package rrc_pkg;
  // AXI4-Lite byte offsets
  localparam logic [7:0] ADDR_SETUP = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CONTROL = 8'h0c;
  // Setup word fields
  localparam int SETUP_WIDTH = 12;
  localparam int OSC_SEL_LSB = 0;
  localparam int WATCHDOG_EN_BIT = 3;
  localparam int CODE_PROT_BIT = 4;
  localparam int PIN_EN_BIT = 5;
  localparam int SPEED_BIT = 6;
  localparam logic [11:0] SETUP_RESET = 12'h07f;
  localparam logic [7:0] PRESCALE_RESET = 8'hff;
  // Status fields
  localparam int ST_CHIP_RESET = 0;
  localparam int ST_TIMER_RUN = 1;
  localparam int ST_CLEAR_LEVEL = 2;
  localparam int ST_SHORT = 3;
  // Control fields
  localparam int CT_SOFT_POR = 0;
  localparam int CT_LOAD_SETUP = 1;
  // Timing
  localparam int CLOCK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHORT_TIMER_NS = 1125000;
  localparam int LONG_TIMER_NS = 18000000;
  localparam int SHORT_TIMER_CYCLES = SHORT_TIMER_NS / CLK_PERIOD_NS;
  localparam int LONG_TIMER_CYCLES = LONG_TIMER_NS / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH = 21;
  // Oscillator frequencies in kHz
  localparam logic [15:0] OSC_FAST_KHZ = 16'h1f40;
  localparam logic [15:0] OSC_SLOW_KHZ = 16'h0fa0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* verilog/rrc_cfg_if.sv */
// Interface: decoded setup word fields from decoder to sequencer
`timescale 1ns/1ns
`default_nettype none
interface rrc_cfg_if;
  logic speed_fast;
  logic pin_enable;
  logic short_timer;
  logic watchdog_on;
  logic clock_out_on;
  logic [2:0] osc_mode;
  modport source (output speed_fast, pin_enable, short_timer, watchdog_on, clock_out_on, osc_mode);
  modport sink (input speed_fast, pin_enable, short_timer, watchdog_on, clock_out_on, osc_mode);
endinterface
`default_nettype wire

/* verilog/rrc_cfg_decode.sv */
// Decoder: splits the setup word into oscillator, pin and watchdog choices
`timescale 1ns/1ns
`default_nettype none
module rrc_cfg_decode (
  input wire logic [11:0] setup_word, // Held configuration word
  rrc_cfg_if.source cfg // Decoded fields
);
  logic [2:0] mode;
  assign mode = setup_word[rrc_pkg::OSC_SEL_LSB +: 3];
  assign cfg.osc_mode = mode;
  assign cfg.speed_fast = setup_word[rrc_pkg::SPEED_BIT];
  assign cfg.pin_enable = setup_word[rrc_pkg::PIN_EN_BIT];
  assign cfg.watchdog_on = setup_word[rrc_pkg::WATCHDOG_EN_BIT];
  // Modes 000..010 keep the long timer; 011 and up select the short one
  assign cfg.short_timer = (mode >= 3'h3);
  // Odd modes from 011 up drive the clock output pin
  assign cfg.clock_out_on = mode[0] & (mode >= 3'h3);
endmodule
`default_nettype wire

/* verilog/rrc_top.sv */
// Reset release sequencer with configuration word and AXI4-Lite registers
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module rrc_top #(
  parameter int LONG_CYCLES = rrc_pkg::LONG_TIMER_CYCLES, // Long timer count
  parameter int SHORT_CYCLES = rrc_pkg::SHORT_TIMER_CYCLES // Short timer count
) (
  input wire logic clock, // System clock, 100 MHz
  input wire logic rst_b, // Power-up event, active low
  input wire logic [11:0] setup_strap, // Nonvolatile setup word image
  input wire logic master_clear_n_in, // Reset pin level
  input wire logic portb_pin3_out, // Port data for pin when freed
  input wire logic portb_pin3_drive, // Port drive request when freed
  output logic master_clear_n_out, // Pin output value
  output logic master_clear_n_oe, // Pin output enable
  output logic portb_pin3_in, // Pin level seen by port logic
  output logic chip_reset, // On-chip reset, high while held
  output logic watchdog_enable, // Watchdog timer enable
  output logic internal_osc_speed_select, // 1 = fast oscillator
  output logic [15:0] osc_khz, // Selected oscillator rate
  output logic clock_output_en, // Clock output pin function on
  output logic [2:0] osc_mode, // Oscillator mode field
  output logic [7:0] prescaler_wake_control, // Written option byte
  input wire logic [7:0] s_axi_awaddr, // AXI write address
  input wire logic s_axi_awvalid, // AXI write address valid
  output logic s_axi_awready, // AXI write address ready
  input wire logic [31:0] s_axi_wdata, // AXI write data
  input wire logic [3:0] s_axi_wstrb, // AXI write strobes
  input wire logic s_axi_wvalid, // AXI write data valid
  output logic s_axi_wready, // AXI write data ready
  output logic [1:0] s_axi_bresp, // AXI write response
  output logic s_axi_bvalid, // AXI write response valid
  input wire logic s_axi_bready, // AXI write response ready
  input wire logic [7:0] s_axi_araddr, // AXI read address
  input wire logic s_axi_arvalid, // AXI read address valid
  output logic s_axi_arready, // AXI read address ready
  output logic [31:0] s_axi_rdata, // AXI read data
  output logic [1:0] s_axi_rresp, // AXI read response
  output logic s_axi_rvalid, // AXI read valid
  input wire logic s_axi_rready // AXI read ready
);
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_COUNT = 2'b01,
    ST_RUN = 2'b10
  } rrc_state_type;

  rrc_cfg_if cfg_bus ();
  rrc_state_type state_reg;
  logic [11:0] setup_reg;
  logic setup_loaded_reg;
  logic [7:0] option_reg;
  logic [20:0] timer_reg;
  logic soft_por_reg;
  logic latch_reg;
  logic clear_level;
  logic [20:0] period;
  logic timer_done;

  rrc_cfg_decode u_decode (
    .setup_word(setup_reg),
    .cfg(cfg_bus)
  );

  // Setup word is caught after reset release, never through the async reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      setup_reg <= rrc_pkg::SETUP_RESET;
      setup_loaded_reg <= 1'b0;
    end else if (!setup_loaded_reg || soft_por_reg) begin
      setup_reg <= setup_strap;
      setup_loaded_reg <= 1'b1;
    end
  end

  // Freed pin ties the clear level high; pin enable selects the pin level
  assign clear_level = cfg_bus.pin_enable ? master_clear_n_in : 1'b1;
  assign master_clear_n_out = portb_pin3_out;
  assign master_clear_n_oe = ~cfg_bus.pin_enable & portb_pin3_drive;
  assign portb_pin3_in = cfg_bus.pin_enable ? 1'b0 : master_clear_n_in;

  assign period = cfg_bus.short_timer ? SHORT_CYCLES[20:0] : LONG_CYCLES[20:0];
  assign timer_done = (timer_reg == period - 21'h000001);

  // Power-up and soft reload both restart the sequence, whatever the pin setting
  logic restart;
  assign restart = soft_por_reg | ~setup_loaded_reg;

  // Hold until the clear level is high, count one period, then run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_HOLD;
    end else if (restart) begin
      state_reg <= ST_HOLD;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          if (clear_level) begin
            state_reg <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (!clear_level) begin
            state_reg <= ST_HOLD;
          end else if (timer_done) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          // External clear low puts the chip back in reset
          if (!clear_level) begin
            state_reg <= ST_HOLD;
          end
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

  // Timer only advances while counting with the clear level high; any other
  // cycle zeroes it, so a low clear restarts the full period from its next rise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timer_reg <= '0;
    end else if (restart) begin
      timer_reg <= '0;
    end else if (state_reg == ST_COUNT && clear_level && !timer_done) begin
      timer_reg <= timer_reg + 21'h000001;
    end else begin
      timer_reg <= '0;
    end
  end

  // Latch clears only on expiry; a low clear or a stray state sets it again
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg <= 1'b1;
    end else if (restart) begin
      latch_reg <= 1'b1;
    end else if (state_reg == ST_COUNT && clear_level && timer_done) begin
      latch_reg <= 1'b0;
    end else if (!clear_level || (state_reg != ST_COUNT && state_reg != ST_RUN)) begin
      latch_reg <= 1'b1;
    end
  end

  assign chip_reset = latch_reg;
  assign watchdog_enable = cfg_bus.watchdog_on;
  assign internal_osc_speed_select = cfg_bus.speed_fast;
  assign osc_khz = cfg_bus.speed_fast ? rrc_pkg::OSC_FAST_KHZ : rrc_pkg::OSC_SLOW_KHZ;
  assign clock_output_en = cfg_bus.clock_out_on;
  assign osc_mode = cfg_bus.osc_mode;
  assign prescaler_wake_control = option_reg;

  // AXI4-Lite write channel: address and data latched independently
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rrc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          rrc_pkg::ADDR_PRESCALE, rrc_pkg::ADDR_CONTROL: s_axi_bresp <= rrc_pkg::RESP_OKAY;
          default: s_axi_bresp <= rrc_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Option byte is write-only to software; control bits self-clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      option_reg <= rrc_pkg::PRESCALE_RESET;
      soft_por_reg <= 1'b0;
    end else begin
      soft_por_reg <= 1'b0;
      if (do_write && aw_addr_reg == rrc_pkg::ADDR_PRESCALE && w_strb_reg[0]) begin
        option_reg <= w_data_reg[7:0];
      end
      if (do_write && aw_addr_reg == rrc_pkg::ADDR_CONTROL && w_strb_reg[0]) begin
        soft_por_reg <= w_data_reg[rrc_pkg::CT_SOFT_POR] | w_data_reg[rrc_pkg::CT_LOAD_SETUP];
      end
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rd_value;
  logic rd_ok;
  always_comb begin
    rd_value = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      rrc_pkg::ADDR_SETUP: rd_value[11:0] = setup_reg;
      rrc_pkg::ADDR_PRESCALE: rd_value = '0;
      rrc_pkg::ADDR_CONTROL: rd_value = '0;
      rrc_pkg::ADDR_STATUS: begin
        rd_value[rrc_pkg::ST_CHIP_RESET] = latch_reg;
        rd_value[rrc_pkg::ST_TIMER_RUN] = (state_reg == ST_COUNT);
        rd_value[rrc_pkg::ST_CLEAR_LEVEL] = clear_level;
        rd_value[rrc_pkg::ST_SHORT] = cfg_bus.short_timer;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? rrc_pkg::RESP_OKAY : rrc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* testbench/rrc_pin_model.sv */
// Far side model: reset pin with weak pull-up and external hold-low switch
`timescale 1ns/1ns
`default_nettype none
module rrc_pin_model (
  input wire logic hold_low, // Switch pulls pin low
  input wire logic dut_oe, // Device drives pin
  input wire logic dut_out, // Device pin value
  output logic pin // Resolved pin level
);
  // Device drive wins; the switch only acts while the pin is an input
  assign pin = dut_oe ? dut_out : !hold_low;
endmodule
`default_nettype wire

/* testbench/rrc_top_asserts.sv */
// Checker: reset release, config decode and bus response properties
`timescale 1ns/1ns
`default_nettype none
module rrc_top_asserts #(
  parameter int LONG_CYCLES = 20, // Long count
  parameter int SHORT_CYCLES = 8 // Short count
) (
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset
  input wire logic chip_reset, // Chip reset
  input wire logic internal_osc_speed_select, // Speed
  input wire logic [15:0] osc_khz, // Rate
  input wire logic clock_output_en, // Clock out
  input wire logic [2:0] osc_mode, // Mode
  input wire logic master_clear_n_oe, // Pin enable
  input wire logic portb_pin3_drive, // Port request
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready // R ready
);
  int hi_cnt;
  // Consecutive cycles spent in chip reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= 0;
    end else begin
      hi_cnt <= chip_reset ? hi_cnt + 1 : 0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_speed;
    osc_khz == (internal_osc_speed_select ? 16'h1f40 : 16'h0fa0);
  endproperty
  a_speed: assert property (p_speed) else $error("rate does not follow speed bit");
  property p_clock_out;
    clock_output_en == (osc_mode inside {3'h3, 3'h5, 3'h7});
  endproperty
  a_clock_out: assert property (p_clock_out) else $error("clock out wrong for mode");
  property p_oe;
    master_clear_n_oe |-> portb_pin3_drive;
  endproperty
  a_oe: assert property (p_oe) else $error("pin driven without request");
  property p_por;
    $rose(rst_b) |-> chip_reset ##1 chip_reset;
  endproperty
  a_por: assert property (p_por) else $error("chip left reset at power-up");
  property p_release;
    $fell(chip_reset) |-> hi_cnt >= SHORT_CYCLES - 1;
  endproperty
  a_release: assert property (p_release) else $error("released before timer period");
  property p_mode_load;
    $changed(osc_mode) |-> chip_reset;
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode changed outside reset");
  property p_bone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bone: assert property (p_bone) else $error("write response repeated");
  property p_rone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rone: assert property (p_rone) else $error("read response repeated");
endmodule
bind rrc_top rrc_top_asserts #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) u_chk (
  .clock, .rst_b, .chip_reset, .internal_osc_speed_select, .osc_khz, .clock_output_en,
  .osc_mode, .master_clear_n_oe, .portb_pin3_drive, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

/* testbench/tb_reset_release_and_config_word.sv */
// Testbench: config decode, reset release timing and register access
`timescale 1ns/1ns
`default_nettype none
module tb_reset_release_and_config_word;
  localparam int LNG = 20;
  localparam int SHT = 8;
  typedef struct {logic [11:0] strap; logic [15:0] khz; logic clk_out; int per;} rrc_row_type;
  rrc_row_type rows[8] = '{'{12'h068, 16'h1f40, 1'b0, LNG}, '{12'h021, 16'h0fa0, 1'b0, LNG},
    '{12'h06a, 16'h1f40, 1'b0, LNG}, '{12'h02b, 16'h0fa0, 1'b1, SHT},
    '{12'h064, 16'h1f40, 1'b0, SHT}, '{12'h025, 16'h0fa0, 1'b1, SHT},
    '{12'h06e, 16'h1f40, 1'b0, SHT}, '{12'h027, 16'h0fa0, 1'b1, SHT}};
  logic clock = 1'b0, rst_b = 1'b0, hold_low = 1'b1, master_clear_n_in;
  logic portb_pin3_out = 1'b0, portb_pin3_drive = 1'b1;
  logic [11:0] setup_strap = 12'h003;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, prescaler_wake_control;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic master_clear_n_out, master_clear_n_oe, portb_pin3_in, chip_reset, watchdog_enable;
  logic internal_osc_speed_select, clock_output_en, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [15:0] osc_khz;
  logic [2:0] osc_mode;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0;
  int tests_run = 0;
  rrc_top #(.LONG_CYCLES(LNG), .SHORT_CYCLES(SHT)) dut (.clock, .rst_b, .setup_strap,
    .master_clear_n_in, .portb_pin3_out, .portb_pin3_drive, .master_clear_n_out,
    .master_clear_n_oe, .portb_pin3_in, .chip_reset, .watchdog_enable, .internal_osc_speed_select,
    .osc_khz, .clock_output_en, .osc_mode, .prescaler_wake_control, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rrc_pin_model u_pin (.hold_low, .dut_oe(master_clear_n_oe), .dut_out(master_clear_n_out),
    .pin(master_clear_n_in));
  always #5 clock = ~clock;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Handshakes are judged at the falling edge, then acted on after the next rising edge
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clock);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clock);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(r, er);
    @(posedge clock);
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clock);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clock);
      if (ah) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(d, ed);
    check(r, er);
    @(posedge clock);
  endtask
  initial begin
    #100000;
    fails++;
    end_of_test;
  end
  initial begin
    cyc(12);
    rst_b <= 1'b1;
    cyc(SHT + 6);
    @(negedge clock);
    check(chip_reset, 1'b0);
    check(prescaler_wake_control, 8'hff);
    check(master_clear_n_oe, 1'b1);
    check(portb_pin3_in, 1'b0);
    @(posedge clock);
    portb_pin3_out <= 1'b1;
    @(negedge clock);
    check(portb_pin3_in, 1'b1);
    @(posedge clock);
    axi_wr(8'h04, 32'h5a, 2'h0);
    check(prescaler_wake_control, 8'h5a);
    axi_rd(8'h04, 32'h0, 2'h0);
    axi_rd(8'h10, 32'h0, 2'h2);
    axi_wr(8'h00, 32'h0, 2'h2);
    axi_rd(8'h00, 32'h003, 2'h0);
    axi_rd(8'h08, 32'h00c, 2'h0);
    foreach (rows[i]) begin
      setup_strap <= rows[i].strap;
      axi_wr(8'h0c, i[0] ? 32'h2 : 32'h1, 2'h0);
      cyc(3);
      @(negedge clock);
      check(chip_reset, 1'b1);
      check(master_clear_n_oe, 1'b0);
      check(watchdog_enable, rows[i].strap[3]);
      check(internal_osc_speed_select, rows[i].strap[6]);
      check(osc_khz, rows[i].khz);
      check(clock_output_en, rows[i].clk_out);
      check(osc_mode, rows[i].strap[2:0]);
      @(posedge clock);
      axi_rd(8'h00, {20'h0, rows[i].strap}, 2'h0);
      axi_rd(8'h08, {28'h0, rows[i].per == SHT, 3'b001}, 2'h0);
      hold_low <= 1'b0;
      cyc(rows[i].per);
      @(negedge clock);
      check(chip_reset, 1'b1);
      cyc(1);
      @(negedge clock);
      check(chip_reset, 1'b0);
      @(posedge clock);
      hold_low <= 1'b1;
      cyc(3);
      @(negedge clock);
      check(chip_reset, 1'b1);
      @(posedge clock);
    end
    // Power-up while the pin holds clear low: reset lasts until the pin lets go
    rst_b <= 1'b0;
    cyc(3);
    @(negedge clock);
    check(chip_reset, 1'b1);
    check(osc_mode, rrc_pkg::SETUP_RESET[2:0]);
    @(posedge clock);
    rst_b <= 1'b1;
    cyc(SHT + 4);
    @(negedge clock);
    check(chip_reset, 1'b1);
    @(posedge clock);
    hold_low <= 1'b0;
    cyc(SHT);
    @(negedge clock);
    check(chip_reset, 1'b1);
    cyc(1);
    @(negedge clock);
    check(chip_reset, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
